// File: ssx_core.sv
// Wishbone slave that executes subtract, swap, direction, xor and sleep operations.
`timescale 1ns/10ps

// Summary of operation
// - The literal minus accumulator operation puts literal minus accumulator into the accumulator and updates carry, half and zero.
// - The file minus accumulator operation computes register minus accumulator and sends it to the accumulator for destination 0 or the register for 1.
// - Each subtraction without borrow clears carry if the accumulator exceeds the operand and half if its low nibble exceeds the operand's, else sets them.
// - The borrow subtraction computes register minus accumulator minus inverted carry to the selected destination and updates carry, half and zero.
// - Sleep clears the watchdog counter and its prescaler and on the same edge stops command execution with the oscillator request raised.
// - Sleep sets the timeout status bit, clears the sleep flag and leaves every other flag alone.
// - The nibble exchange swaps the two nibbles of a register into the selected destination without touching any flag.
// - The direction load copies the accumulator into port A, B or C direction for operand 5, 6 or 7 and changes no flag.
// - The literal xor puts accumulator xor literal into the accumulator and updates only the zero flag.
// - The register xor puts accumulator xor register into the selected destination and updates only the zero flag.
module ssx_core #(
  parameter int DEPTH = 128,
  parameter logic [7:0] PRESCALE_LAST = ssx_pkg::PRESCALE_LAST_DEF
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [11:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output logic [7:0] PORT_A_DIR_OUT,
  output logic [7:0] PORT_B_DIR_OUT,
  output logic [7:0] PORT_C_DIR_OUT,
  output logic SLEEP_OUT
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam int AW = ssx_pkg::ADDR_W;
  localparam int IDX_W = $clog2(DEPTH);
  localparam logic [11:0] FILE_SPAN = AW'(4 * DEPTH);

  typedef struct packed {
    logic [7:0] acc;
    logic carry;
    logic half;
    logic zero;
    logic timeout;
    logic sleepf;
    logic asleep;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [7:0] wdog_cnt;
    logic [7:0] presc;
    logic [31:0] cmd;
    logic pending;
    logic ack;
    logic [31:0] rdata;
    logic [DEPTH-1:0][7:0] file;
  } ssx_state_t;

  ssx_state_t r_reg;
  ssx_state_t r_next;

  // Byte lanes not selected keep their old contents.
  function automatic logic [31:0] ssx_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] sel);
    logic [31:0] w;
    w = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        w[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    ssx_merge = w;
  endfunction : ssx_merge

  // ****************************************************************
  // Command decode and ALU hookup
  // ****************************************************************
  ssx_alu_if alu_bus();

  ssx_alu_unit u_alu (
    .bus(alu_bus.alu)
  );

  ssx_pkg::ssx_op_t op;
  logic dest;
  logic [6:0] fsel;
  logic [7:0] lit;
  logic f_ok;
  logic [IDX_W-1:0] fidx;
  logic [7:0] f_val;
  logic exec;
  logic lit_op;

  assign op = ssx_pkg::ssx_op_t'(r_reg.cmd[ssx_pkg::CMD_OP_LSB +: 4]);
  assign dest = r_reg.cmd[ssx_pkg::CMD_DEST_BIT];
  assign fsel = r_reg.cmd[ssx_pkg::CMD_FILE_LSB +: ssx_pkg::FILE_W];
  assign lit = r_reg.cmd[ssx_pkg::CMD_LIT_LSB +: 8];
  assign f_ok = int'(fsel) < DEPTH;
  assign fidx = fsel[IDX_W-1:0];
  assign f_val = f_ok ? r_reg.file[fidx] : 8'h00;
  // No command runs while asleep because the oscillator is considered stopped.
  assign exec = r_reg.pending & ~r_reg.asleep;
  assign lit_op = (op == ssx_pkg::OP_LITERAL_MINUS_ACC) || (op == ssx_pkg::OP_LITERAL_XOR);

  assign alu_bus.op = op;
  assign alu_bus.acc_val = r_reg.acc;
  assign alu_bus.opnd_val = lit_op ? lit : f_val;
  assign alu_bus.carry_in = r_reg.carry;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic bus_req;
  logic [11:0] file_off;
  logic in_file;
  logic [IDX_W-1:0] bus_idx;
  logic [31:0] rd_word;

  assign bus_req = WB_CYC_IN & WB_STB_IN;
  assign file_off = WB_ADR_IN - ssx_pkg::OFS_FILE_BASE;
  assign in_file = (WB_ADR_IN >= ssx_pkg::OFS_FILE_BASE) && (file_off < FILE_SPAN);
  assign bus_idx = file_off[IDX_W+1:2];

  always_comb begin
    rd_word = 32'h0000_0000;
    if (in_file) begin
      rd_word[7:0] = r_reg.file[bus_idx];
    end else begin
      unique case (WB_ADR_IN)
        ssx_pkg::OFS_CMD: rd_word = r_reg.cmd;
        ssx_pkg::OFS_ACC: rd_word[7:0] = r_reg.acc;
        ssx_pkg::OFS_STATUS: begin
          rd_word[ssx_pkg::ST_CARRY] = r_reg.carry;
          rd_word[ssx_pkg::ST_HALF] = r_reg.half;
          rd_word[ssx_pkg::ST_ZERO] = r_reg.zero;
          rd_word[ssx_pkg::ST_SLEEPF] = r_reg.sleepf;
          rd_word[ssx_pkg::ST_TIMEOUT] = r_reg.timeout;
        end
        ssx_pkg::OFS_DIR: rd_word[23:0] = {r_reg.dir_c, r_reg.dir_b, r_reg.dir_a};
        ssx_pkg::OFS_WDOG: rd_word[15:0] = {r_reg.presc, r_reg.wdog_cnt};
        ssx_pkg::OFS_CTRL: rd_word[ssx_pkg::CTRL_WAKE_BIT] = r_reg.asleep;
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_next = r_reg;
    // The one-shot clear comes first so that a new command in the same cycle wins.
    if (r_reg.pending) begin
      r_next.pending = 1'b0;
    end
    // Ack follows the request by one cycle and drops after one cycle.
    r_next.ack = bus_req & ~r_reg.ack;
    if (bus_req & ~r_reg.ack) begin
      r_next.rdata = rd_word;
    end
    // A write takes effect on the edge at which the master sees ack.
    if (bus_req & r_reg.ack & WB_WE_IN) begin
      if (in_file) begin
        if (WB_SEL_IN[0]) begin
          r_next.file[bus_idx] = WB_DAT_IN[7:0];
        end
      end else begin
        unique case (WB_ADR_IN)
          ssx_pkg::OFS_CMD: begin
            r_next.cmd = ssx_merge(r_reg.cmd, WB_DAT_IN, WB_SEL_IN);
            // Commands that arrive during sleep are dropped, not queued.
            r_next.pending = ~r_reg.asleep;
          end
          ssx_pkg::OFS_ACC: begin
            if (WB_SEL_IN[0]) begin
              r_next.acc = WB_DAT_IN[7:0];
            end
          end
          ssx_pkg::OFS_STATUS: begin
            if (WB_SEL_IN[0]) begin
              r_next.carry = WB_DAT_IN[ssx_pkg::ST_CARRY];
              r_next.half = WB_DAT_IN[ssx_pkg::ST_HALF];
              r_next.zero = WB_DAT_IN[ssx_pkg::ST_ZERO];
            end
          end
          ssx_pkg::OFS_CTRL: begin
            if (WB_SEL_IN[0] & WB_DAT_IN[ssx_pkg::CTRL_WAKE_BIT]) begin
              r_next.asleep = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Free-running watchdog time base.
    if (r_reg.presc == PRESCALE_LAST) begin
      r_next.presc = 8'h00;
      r_next.wdog_cnt = r_reg.wdog_cnt + 8'h01;
    end else begin
      r_next.presc = r_reg.presc + 8'h01;
    end
    if (exec) begin
      unique case (op)
        ssx_pkg::OP_LITERAL_MINUS_ACC: begin
          r_next.acc = alu_bus.result;
          r_next.carry = alu_bus.carry_out;
          r_next.half = alu_bus.half_out;
          r_next.zero = alu_bus.zero_out;
        end
        ssx_pkg::OP_FILE_MINUS_ACC,
        ssx_pkg::OP_FILE_MINUS_ACC_BORROW: begin
          if (!dest) begin
            r_next.acc = alu_bus.result;
          end else if (f_ok) begin
            r_next.file[fidx] = alu_bus.result;
          end
          r_next.carry = alu_bus.carry_out;
          r_next.half = alu_bus.half_out;
          r_next.zero = alu_bus.zero_out;
        end
        ssx_pkg::OP_NIBBLE_EXCHANGE,
        ssx_pkg::OP_REGISTER_XOR: begin
          if (!dest) begin
            r_next.acc = alu_bus.result;
          end else if (f_ok) begin
            r_next.file[fidx] = alu_bus.result;
          end
          if (op == ssx_pkg::OP_REGISTER_XOR) begin
            r_next.zero = alu_bus.zero_out;
          end
        end
        ssx_pkg::OP_DIRECTION_LOAD: begin
          // Operands outside 5 to 7 select no direction register and do nothing.
          if (fsel == ssx_pkg::DIR_SEL_A) begin
            r_next.dir_a = alu_bus.result;
          end else if (fsel == ssx_pkg::DIR_SEL_B) begin
            r_next.dir_b = alu_bus.result;
          end else if (fsel == ssx_pkg::DIR_SEL_C) begin
            r_next.dir_c = alu_bus.result;
          end
        end
        ssx_pkg::OP_LITERAL_XOR: begin
          r_next.acc = alu_bus.result;
          r_next.zero = alu_bus.zero_out;
        end
        ssx_pkg::OP_SLEEP: begin
          r_next.wdog_cnt = ssx_pkg::WDOG_CLEAR;
          r_next.presc = 8'h00;
          r_next.asleep = 1'b1;
          r_next.timeout = 1'b1;
          r_next.sleepf = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      r_reg <= '0;
      r_reg.timeout <= ssx_pkg::RST_TIMEOUT;
      r_reg.sleepf <= ssx_pkg::RST_SLEEPF;
    end else begin
      r_reg <= r_next;
    end
  end

  assign WB_ACK_OUT = r_reg.ack;
  assign WB_DAT_OUT = r_reg.rdata;
  assign PORT_A_DIR_OUT = r_reg.dir_a;
  assign PORT_B_DIR_OUT = r_reg.dir_b;
  assign PORT_C_DIR_OUT = r_reg.dir_c;
  assign SLEEP_OUT = r_reg.asleep;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [7:0] h_lit_diff;
  logic [7:0] h_file_diff;
  logic [7:0] h_borrow_diff;
  logic [7:0] h_swapped;
  logic [7:0] h_lit_xor;
  logic [7:0] h_file_xor;
  logic h_le;
  logic h_lo_le;

  assign h_lit_diff = lit - r_reg.acc;
  assign h_file_diff = f_val - r_reg.acc;
  assign h_borrow_diff = f_val - r_reg.acc - {7'h00, ~r_reg.carry};
  assign h_swapped = {f_val[3:0], f_val[7:4]};
  assign h_lit_xor = lit ^ r_reg.acc;
  assign h_file_xor = f_val ^ r_reg.acc;
  assign h_le = r_reg.acc <= alu_bus.opnd_val;
  assign h_lo_le = r_reg.acc[3:0] <= alu_bus.opnd_val[3:0];

  default clocking ck @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);

  lit_sub_acc_a: assert property (exec && op == ssx_pkg::OP_LITERAL_MINUS_ACC |=>
    r_reg.acc == $past(h_lit_diff)) else $error("literal subtract result wrong");
  file_sub_dest_a: assert property (exec && op == ssx_pkg::OP_FILE_MINUS_ACC && !dest |=>
    r_reg.acc == $past(h_file_diff) && $stable(r_reg.file)) else $error("file subtract wrong");
  sub_borrow_flags_a: assert property (exec &&
    (op == ssx_pkg::OP_LITERAL_MINUS_ACC || op == ssx_pkg::OP_FILE_MINUS_ACC) |=>
    r_reg.carry == $past(h_le) && r_reg.half == $past(h_lo_le)) else $error("borrow flags wrong");
  borrow_sub_file_a: assert property (exec && op == ssx_pkg::OP_FILE_MINUS_ACC_BORROW &&
    dest && f_ok |=> r_reg.file[fidx] == $past(h_borrow_diff) && $stable(r_reg.acc))
    else $error("borrow subtract wrong");
  sleep_wdog_clear_a: assert property (exec && op == ssx_pkg::OP_SLEEP |=>
    r_reg.wdog_cnt == 8'h00 && r_reg.presc == 8'h00 && SLEEP_OUT ##1 SLEEP_OUT)
    else $error("sleep did not clear watchdog");
  sleep_status_a: assert property (exec && op == ssx_pkg::OP_SLEEP |=> r_reg.timeout &&
    !r_reg.sleepf && $stable(r_reg.carry) && $stable(r_reg.half) && $stable(r_reg.zero))
    else $error("sleep status bits wrong");
  swap_nibbles_a: assert property (exec && op == ssx_pkg::OP_NIBBLE_EXCHANGE && dest && f_ok
    |=> r_reg.file[fidx] == $past(h_swapped) && $stable({r_reg.carry, r_reg.half, r_reg.zero}))
    else $error("nibble exchange wrong");
  dir_load_a: assert property (exec && op == ssx_pkg::OP_DIRECTION_LOAD &&
    fsel == ssx_pkg::DIR_SEL_B |=> PORT_B_DIR_OUT == $past(r_reg.acc) && $stable(PORT_A_DIR_OUT)
    && $stable(PORT_C_DIR_OUT) && $stable(r_reg.zero)) else $error("direction load wrong");
  lit_xor_a: assert property (exec && op == ssx_pkg::OP_LITERAL_XOR |=>
    r_reg.acc == $past(h_lit_xor) && $stable(r_reg.carry) && $stable(r_reg.half))
    else $error("literal xor wrong");
  reg_xor_a: assert property (exec && op == ssx_pkg::OP_REGISTER_XOR && dest && f_ok |=>
    r_reg.file[fidx] == $past(h_file_xor) && $stable(r_reg.acc)) else $error("register xor wrong");
  zero_flag_a: assert property (exec && (op == ssx_pkg::OP_LITERAL_XOR ||
    op == ssx_pkg::OP_LITERAL_MINUS_ACC) |=> r_reg.zero == (r_reg.acc == 8'h00))
    else $error("zero flag wrong");
  bus_ack_pulse_a: assert property (bus_req && !WB_ACK_OUT |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
    else $error("ack not a one cycle answer");

  sleep_seen_c: cover property (exec && op == ssx_pkg::OP_SLEEP);
  borrow_seen_c: cover property (exec && op == ssx_pkg::OP_FILE_MINUS_ACC_BORROW && !r_reg.carry);
  wake_seen_c: cover property (SLEEP_OUT ##[1:20] !SLEEP_OUT);
  zero_seen_c: cover property (exec && alu_bus.zero_out);

endmodule : ssx_core

// File: ssx_pkg.sv
// Package with register map, field layout, reset values and operation codes of the ALU block.
package ssx_pkg;

  // ****************************************************************
  // Bus geometry and register offsets
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_ACC = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_DIR = 12'h00c;
  localparam logic [11:0] OFS_WDOG = 12'h010;
  localparam logic [11:0] OFS_CTRL = 12'h014;
  localparam logic [11:0] OFS_FILE_BASE = 12'h200;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 4;
  localparam int CMD_FILE_LSB = 8;
  localparam int CMD_LIT_LSB = 16;
  localparam int FILE_W = 7;
  localparam int ST_CARRY = 0;
  localparam int ST_HALF = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_SLEEPF = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int CTRL_WAKE_BIT = 0;
  localparam logic [6:0] DIR_SEL_A = 7'h05;
  localparam logic [6:0] DIR_SEL_B = 7'h06;
  localparam logic [6:0] DIR_SEL_C = 7'h07;

  // ****************************************************************
  // Reset values and timing counts
  // ****************************************************************
  localparam logic RST_TIMEOUT = 1'b1;
  localparam logic RST_SLEEPF = 1'b1;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [7:0] PRESCALE_LAST_DEF = 8'hff;

  // ****************************************************************
  // Operation codes
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_LITERAL_MINUS_ACC = 4'h1,
    OP_FILE_MINUS_ACC = 4'h2,
    OP_FILE_MINUS_ACC_BORROW = 4'h3,
    OP_NIBBLE_EXCHANGE = 4'h4,
    OP_DIRECTION_LOAD = 4'h5,
    OP_LITERAL_XOR = 4'h6,
    OP_REGISTER_XOR = 4'h7,
    OP_SLEEP = 4'h8
  } ssx_op_t;

endpackage : ssx_pkg

// File: ssx_alu_if.sv
// Interface between the sequencing logic and the combinational ALU.
`timescale 1ns/10ps
interface ssx_alu_if;
  ssx_pkg::ssx_op_t op;
  logic [7:0] acc_val;
  logic [7:0] opnd_val;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  logic half_out;
  logic zero_out;

  modport seq (output op, output acc_val, output opnd_val, output carry_in,
               input result, input carry_out, input half_out, input zero_out);
  modport alu (input op, input acc_val, input opnd_val, input carry_in,
               output result, output carry_out, output half_out, output zero_out);
endinterface : ssx_alu_if

// File: ssx_alu_unit.sv
// Combinational ALU for the subtract, swap, xor and direction operations.
`timescale 1ns/10ps
module ssx_alu_unit (
  ssx_alu_if.alu bus
);

  // A nibble subtract as x plus inverted y plus carry, so the carry out is the inverse borrow.
  function automatic logic [4:0] ssx_nib_sub(input logic [3:0] x, input logic [3:0] y,
                                             input logic cin);
    ssx_nib_sub = {1'b0, x} + {1'b0, ~y} + {4'h0, cin};
  endfunction : ssx_nib_sub

  logic cin_eff;
  logic [4:0] lo;
  logic [4:0] hi;

  always_comb begin
    cin_eff = (bus.op == ssx_pkg::OP_FILE_MINUS_ACC_BORROW) ? bus.carry_in : 1'b1;
    lo = ssx_nib_sub(bus.opnd_val[3:0], bus.acc_val[3:0], cin_eff);
    hi = ssx_nib_sub(bus.opnd_val[7:4], bus.acc_val[7:4], lo[4]);
    bus.carry_out = hi[4];
    bus.half_out = lo[4];
    unique case (bus.op)
      ssx_pkg::OP_LITERAL_MINUS_ACC,
      ssx_pkg::OP_FILE_MINUS_ACC,
      ssx_pkg::OP_FILE_MINUS_ACC_BORROW: begin
        bus.result = {hi[3:0], lo[3:0]};
      end
      ssx_pkg::OP_NIBBLE_EXCHANGE: begin
        bus.result = {bus.opnd_val[3:0], bus.opnd_val[7:4]};
      end
      ssx_pkg::OP_LITERAL_XOR,
      ssx_pkg::OP_REGISTER_XOR: begin
        bus.result = bus.acc_val ^ bus.opnd_val;
      end
      ssx_pkg::OP_DIRECTION_LOAD: begin
        bus.result = bus.acc_val;
      end
      default: begin
        bus.result = 8'h00;
      end
    endcase
    bus.zero_out = (bus.result == 8'h00);
  end

endmodule : ssx_alu_unit

// File: subtract_swap_xor_sleep_ops_tb_top.sv
// Self-checking testbench for the subtract, swap, xor and sleep execution block.
`timescale 1ns/10ps
module subtract_swap_xor_sleep_ops_tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic [7:0] dir_a, dir_b, dir_c;
  logic asleep;
  int bad_count = 0;
  int total_checks = 0;
  // Reference state kept by the bench alongside the block.
  logic [7:0] m_acc = 8'h00;
  logic [7:0] m_file [0:127];
  logic [7:0] m_dir [0:2];
  logic m_c = 1'b0, m_h = 1'b0, m_z = 1'b0, m_to = 1'b1, m_pd = 1'b1, m_sleep = 1'b0;
  logic [31:0] rd;

  ssx_core #(.DEPTH(128), .PRESCALE_LAST(8'h03)) dut (.CLK_SYS_IN(clk_sys), .RESET_IN(reset),
    .WB_CYC_IN(wb_cyc), .WB_STB_IN(wb_stb), .WB_WE_IN(wb_we), .WB_ADR_IN(wb_adr),
    .WB_SEL_IN(wb_sel), .WB_DAT_IN(wb_dat_w), .WB_DAT_OUT(wb_dat_r), .WB_ACK_OUT(wb_ack),
    .PORT_A_DIR_OUT(dir_a), .PORT_B_DIR_OUT(dir_b), .PORT_C_DIR_OUT(dir_c),
    .SLEEP_OUT(asleep));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // Bus access and comparison
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Each access starts one edge after the previous one released, so cyc is low one cycle.
  task automatic wb_access(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_dat_r;
    if (n >= 50) bad_count++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_access

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, bad_count);
  endtask : end_test

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // Reference model and operation driver
  // ****************************************************************
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic bin);
    logic [8:0] d;
    logic [4:0] h;
    d = {1'b0, a} - {1'b0, b} - {8'h00, bin};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    return {~d[8], ~h[4], d[7:0]};
  endfunction : sub8

  task automatic set_acc(input logic [7:0] v);
    wb_access(1'b1, ssx_pkg::OFS_ACC, {24'h0, v});
    m_acc = v;
  endtask : set_acc

  task automatic set_file(input logic [6:0] i, input logic [7:0] v);
    wb_access(1'b1, ssx_pkg::OFS_FILE_BASE + {3'h0, i, 2'h0}, {24'h0, v});
    m_file[i] = v;
  endtask : set_file

  task automatic set_flags(input logic [2:0] f);
    wb_access(1'b1, ssx_pkg::OFS_STATUS, {29'h0, f});
    {m_z, m_h, m_c} = f;
  endtask : set_flags

  // Reads back the accumulator, status, file entry i, direction and sleep state, so an unwanted side effect shows too.
  task automatic verify(input logic [6:0] i);
    wb_access(1'b0, ssx_pkg::OFS_ACC, 32'h0);
    check(rd, {24'h0, m_acc});
    wb_access(1'b0, ssx_pkg::OFS_STATUS, 32'h0);
    check(rd, {27'h0, m_to, m_pd, m_z, m_h, m_c});
    wb_access(1'b0, ssx_pkg::OFS_FILE_BASE + {3'h0, i, 2'h0}, 32'h0);
    check(rd, {24'h0, m_file[i]});
    wb_access(1'b0, ssx_pkg::OFS_DIR, 32'h0);
    check(rd, {8'h0, m_dir[2], m_dir[1], m_dir[0]});
    check({8'h0, dir_c, dir_b, dir_a}, {8'h0, m_dir[2], m_dir[1], m_dir[0]});
    check({31'h0, asleep}, {31'h0, m_sleep});
  endtask : verify

  task automatic do_op(input ssx_pkg::ssx_op_t op, input logic d, input logic [6:0] i,
                       input logic [7:0] lit);
    logic [7:0] f, r;
    logic wr;
    f = m_file[i];
    r = 8'h00;
    wr = 1'b0;
    if (!m_sleep) begin
      case (op)
        ssx_pkg::OP_LITERAL_MINUS_ACC: begin
          {m_c, m_h, m_acc} = sub8(lit, m_acc, 1'b0);
          m_z = (m_acc == 8'h00);
        end
        ssx_pkg::OP_FILE_MINUS_ACC, ssx_pkg::OP_FILE_MINUS_ACC_BORROW: begin
          {m_c, m_h, r} = sub8(f, m_acc, (op == ssx_pkg::OP_FILE_MINUS_ACC_BORROW) & ~m_c);
          m_z = (r == 8'h00);
          wr = 1'b1;
        end
        ssx_pkg::OP_NIBBLE_EXCHANGE: begin
          r = {f[3:0], f[7:4]};
          wr = 1'b1;
        end
        ssx_pkg::OP_DIRECTION_LOAD: begin
          if (i >= 7'h05 && i <= 7'h07) m_dir[i - 7'h05] = m_acc;
        end
        ssx_pkg::OP_LITERAL_XOR: begin
          m_acc = m_acc ^ lit;
          m_z = (m_acc == 8'h00);
        end
        ssx_pkg::OP_REGISTER_XOR: begin
          r = m_acc ^ f;
          m_z = (r == 8'h00);
          wr = 1'b1;
        end
        ssx_pkg::OP_SLEEP: begin
          m_to = 1'b1;
          m_pd = 1'b0;
          m_sleep = 1'b1;
        end
        default: ;
      endcase
      if (wr && d) m_file[i] = r;
      else if (wr) m_acc = r;
    end
    wb_access(1'b1, ssx_pkg::OFS_CMD, {8'h00, lit, 1'b0, i, 3'h0, d, op});
    // The watchdog keeps running in sleep, so it is read at once to catch the clear.
    if (op == ssx_pkg::OP_SLEEP) begin
      wb_access(1'b0, ssx_pkg::OFS_WDOG, 32'h0);
      check({16'h0, rd[15:0]}, 32'h0);
    end
    verify(i);
  endtask : do_op

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  logic [7:0] t_acc [0:4] = '{8'h05, 8'h06, 8'h1f, 8'h80, 8'hff};
  logic [7:0] t_lit [0:4] = '{8'h05, 8'h05, 8'h20, 8'h7f, 8'h00};

  initial begin
    for (int k = 0; k < 128; k++) m_file[k] = 8'h00;
    for (int k = 0; k < 3; k++) m_dir[k] = 8'h00;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    verify(7'h00);
    wb_access(1'b0, 12'h100, 32'h0);
    check(rd, 32'h0);
    // A write without byte lane 0 must leave the accumulator alone.
    wb_sel <= 4'he;
    wb_access(1'b1, ssx_pkg::OFS_ACC, 32'h0000_00aa);
    wb_sel <= 4'hf;
    verify(7'h00);
    end_test("reset");
    for (int k = 0; k < 5; k++) begin
      set_acc(t_acc[k]);
      do_op(ssx_pkg::OP_LITERAL_MINUS_ACC, 1'b0, 7'h00, t_lit[k]);
    end
    set_file(7'h09, 8'h40);
    set_acc(8'h41);
    do_op(ssx_pkg::OP_FILE_MINUS_ACC, 1'b0, 7'h09, 8'h00);
    set_acc(8'h10);
    do_op(ssx_pkg::OP_FILE_MINUS_ACC, 1'b1, 7'h09, 8'h00);
    set_file(7'h7f, 8'h27);
    do_op(ssx_pkg::OP_FILE_MINUS_ACC, 1'b1, 7'h7f, 8'h00);
    set_file(7'h0a, 8'h30);
    for (int k = 0; k < 4; k++) begin
      set_flags({2'b00, k[0]});
      set_acc(k[1] ? 8'h30 : 8'h10);
      do_op(ssx_pkg::OP_FILE_MINUS_ACC_BORROW, k[1], 7'h0a, 8'h00);
    end
    end_test("subtract");
    set_flags(3'h7);
    set_file(7'h14, 8'ha5);
    do_op(ssx_pkg::OP_NIBBLE_EXCHANGE, 1'b0, 7'h14, 8'h00);
    do_op(ssx_pkg::OP_NIBBLE_EXCHANGE, 1'b1, 7'h14, 8'h00);
    do_op(ssx_pkg::OP_NOP, 1'b1, 7'h14, 8'h00);
    wb_access(1'b0, ssx_pkg::OFS_CMD, 32'h0);
    check(rd, {8'h00, 8'h00, 1'b0, 7'h14, 3'h0, 1'b1, 4'h0});
    end_test("swap");
    for (int k = 4; k < 9; k++) begin
      set_acc(8'h11 * k[7:0]);
      do_op(ssx_pkg::OP_DIRECTION_LOAD, 1'b0, k[6:0], 8'h00);
    end
    end_test("direction");
    set_flags(3'h3);
    set_acc(8'h3c);
    do_op(ssx_pkg::OP_LITERAL_XOR, 1'b0, 7'h00, 8'h3c);
    do_op(ssx_pkg::OP_LITERAL_XOR, 1'b0, 7'h00, 8'hc3);
    set_file(7'h1e, 8'h55);
    do_op(ssx_pkg::OP_REGISTER_XOR, 1'b0, 7'h1e, 8'h00);
    do_op(ssx_pkg::OP_REGISTER_XOR, 1'b1, 7'h1e, 8'h00);
    end_test("xor");
    set_flags(3'h5);
    repeat (37) @(posedge clk_sys);
    do_op(ssx_pkg::OP_SLEEP, 1'b0, 7'h00, 8'h00);
    // A command issued while asleep must be dropped, so the model leaves its state alone.
    do_op(ssx_pkg::OP_LITERAL_XOR, 1'b0, 7'h00, 8'hff);
    wb_access(1'b0, ssx_pkg::OFS_CTRL, 32'h0);
    check(rd, 32'h1);
    wb_access(1'b1, ssx_pkg::OFS_CTRL, 32'h1);
    m_sleep = 1'b0;
    verify(7'h00);
    end_test("sleep");
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end
endmodule : subtract_swap_xor_sleep_ops_tb_top
